// ==== src/csf_alu_if.sv ====
// Purpose: Carrier between flag register and arithmetic unit
// Assumes: Purely combinational path inside one cycle
// Notes: Update strobes say which flags the op may touch
`timescale 1ns/1ps
interface csf_alu_if;
  csf_pkg::csf_op_e op;
  csf_pkg::csf_byte_t a;
  csf_pkg::csf_byte_t b;
  logic c_in;
  csf_pkg::csf_byte_t result;
  logic c_out;
  logic ac_out;
  logic ov_out;
  logic z_out;
  logic upd_c;
  logic upd_acov;
  logic upd_z;

  modport core (output op, output a, output b, output c_in,
                input result, input c_out, input ac_out, input ov_out, input z_out,
                input upd_c, input upd_acov, input upd_z);
  modport unit (input op, input a, input b, input c_in,
                output result, output c_out, output ac_out, output ov_out, output z_out,
                output upd_c, output upd_acov, output upd_z);
endinterface

// ==== src/csf_arith.sv ====
// Purpose: Result and flag terms of one ALU instruction
// Assumes: Operand b already selected by the decoder
// Notes: Subtraction runs as a + ~b + 1 for SUB and a + ~b + carry-in for SBC
`include "csf_defs.svh"
`timescale 1ns/1ps
module csf_arith (
  csf_alu_if.unit alu
);

  logic [7:0] opnd;
  logic cin;
  logic [4:0] sum_lo;
  logic [7:0] sum_7;
  logic [8:0] sum_8;

  // ==========================================================
  // Shared adder
  always_comb begin
    opnd = alu.b;
    cin = 1'b0;
    case (alu.op)
      csf_pkg::CSF_OP_ADC: cin = alu.c_in;
      csf_pkg::CSF_OP_SUB: begin
        opnd = ~alu.b;
        cin = 1'b1;
      end
      csf_pkg::CSF_OP_SBC: begin
        opnd = ~alu.b;
        cin = alu.c_in;
      end
      csf_pkg::CSF_OP_INC: begin
        opnd = `CSF_BYTE_ZERO;
        cin = 1'b1;
      end
      csf_pkg::CSF_OP_DEC: opnd = `CSF_BYTE_ONES;
      default: cin = 1'b0;
    endcase
  end

  assign sum_lo = {1'b0, alu.a[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
  assign sum_7 = {1'b0, alu.a[6:0]} + {1'b0, opnd[6:0]} + {7'h00, cin};
  assign sum_8 = {1'b0, alu.a} + {1'b0, opnd} + {8'h00, cin};

  // ==========================================================
  // Result and flag selection
  always_comb begin
    alu.result = sum_8[7:0];
    alu.c_out = sum_8[8];
    alu.ac_out = sum_lo[4];
    alu.ov_out = sum_7[7] ^ sum_8[8];
    alu.upd_c = 1'b0;
    alu.upd_acov = 1'b0;
    alu.upd_z = 1'b0;
    case (alu.op)
      csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_ADC, csf_pkg::CSF_OP_SUB, csf_pkg::CSF_OP_SBC: begin
        alu.upd_c = 1'b1;
        alu.upd_acov = 1'b1;
        alu.upd_z = 1'b1;
      end
      // Increment and decrement leave carry alone, as on the core
      csf_pkg::CSF_OP_INC, csf_pkg::CSF_OP_DEC: alu.upd_z = 1'b1;
      csf_pkg::CSF_OP_AND: begin
        alu.result = alu.a & alu.b;
        alu.upd_z = 1'b1;
      end
      csf_pkg::CSF_OP_OR: begin
        alu.result = alu.a | alu.b;
        alu.upd_z = 1'b1;
      end
      csf_pkg::CSF_OP_XOR: begin
        alu.result = alu.a ^ alu.b;
        alu.upd_z = 1'b1;
      end
      csf_pkg::CSF_OP_CPL: begin
        alu.result = ~alu.a;
        alu.upd_z = 1'b1;
      end
      csf_pkg::CSF_OP_RLC: begin
        alu.result = {alu.a[6:0], alu.c_in};
        alu.c_out = alu.a[7];
        alu.upd_c = 1'b1;
      end
      csf_pkg::CSF_OP_RRC: begin
        alu.result = {alu.c_in, alu.a[7:1]};
        alu.c_out = alu.a[0];
        alu.upd_c = 1'b1;
      end
      csf_pkg::CSF_OP_RL: alu.result = {alu.a[6:0], alu.a[7]};
      csf_pkg::CSF_OP_RR: alu.result = {alu.a[0], alu.a[7:1]};
      default: alu.result = sum_8[7:0];
    endcase
    alu.z_out = (alu.result == `CSF_BYTE_ZERO);
  end

endmodule // csf_arith

// ==== src/csf_defs.svh ====
// Purpose: Constants for the core condition flag block
// Assumes: One instruction presented per clock by the decoder
// Notes: Bit positions, reset values, widths and byte constants only
`ifndef CSF_DEFS_SVH
`define CSF_DEFS_SVH

// ==========================================================
// Field positions
`define CSF_BIT_WDOG 5
`define CSF_BIT_SLEEP 4
`define CSF_BIT_SRANGE 3
`define CSF_BIT_NULL 2
`define CSF_BIT_NIBBLE 1
`define CSF_BIT_CARRY 0
`define CSF_ARITH_MSB 3

// ==========================================================
// Reset values and byte constants
`define CSF_STATUS_RST 8'h00
`define CSF_UNUSED_BITS 2'h0
`define CSF_BYTE_ZERO 8'h00
`define CSF_BYTE_ONES 8'hFF

`endif

// ==== src/csf_pkg.sv ====
// Purpose: Types shared by the core condition flag block
// Assumes: Binary opcodes chosen by the decoder side
// Notes: Values of this enum are the decoder contract
package csf_pkg;

  typedef logic [7:0] csf_byte_t;

  // ==========================================================
  // Instruction classes
  typedef enum logic [4:0] {
    CSF_OP_NONE   = 5'b00000,
    CSF_OP_ADD    = 5'b00001,
    CSF_OP_ADC    = 5'b00010,
    CSF_OP_SUB    = 5'b00011,
    CSF_OP_SBC    = 5'b00100,
    CSF_OP_INC    = 5'b00101,
    CSF_OP_DEC    = 5'b00110,
    CSF_OP_AND    = 5'b00111,
    CSF_OP_OR     = 5'b01000,
    CSF_OP_XOR    = 5'b01001,
    CSF_OP_CPL    = 5'b01010,
    CSF_OP_RLC    = 5'b01011,
    CSF_OP_RRC    = 5'b01100,
    CSF_OP_RL     = 5'b01101,
    CSF_OP_RR     = 5'b01110,
    CSF_OP_WR_ST  = 5'b01111,
    CSF_OP_KICK   = 5'b10000,
    CSF_OP_HALT   = 5'b10001
  } csf_op_e;

endpackage

// ==== src/csf_status_flags.sv ====
// Purpose: Core condition flag register with ALU flag generation
// Assumes: Decoder gives one op per cycle with OP_VALID; expiry is a same-clock pulse
// Notes: Status contents are never pushed by this block on calls or interrupts
`include "csf_defs.svh"
`timescale 1ns/1ps
module csf_status_flags (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic OP_VALID,
  input wire csf_pkg::csf_op_e OP_CODE,
  input wire csf_pkg::csf_byte_t OPERAND_A,
  input wire csf_pkg::csf_byte_t OPERAND_B,
  input wire csf_pkg::csf_byte_t WR_DATA,
  input wire logic WDT_EXPIRE,
  output csf_pkg::csf_byte_t STATUS,
  output csf_pkg::csf_byte_t RESULT,
  output logic RESULT_VALID
);

  csf_alu_if alu ();

  csf_pkg::csf_byte_t status_ff;
  csf_pkg::csf_byte_t result_ff;
  logic result_valid_ff;
  logic [`CSF_ARITH_MSB:0] nxt_arith;
  logic nxt_wdog;
  logic nxt_sleep;
  logic kick;
  logic halt;
  logic wr_st;
  logic alu_op;

  // ==========================================================
  // Decode
  assign kick = OP_VALID && (OP_CODE == csf_pkg::CSF_OP_KICK);
  assign halt = OP_VALID && (OP_CODE == csf_pkg::CSF_OP_HALT);
  assign wr_st = OP_VALID && (OP_CODE == csf_pkg::CSF_OP_WR_ST);
  assign alu_op = OP_VALID && !kick && !halt && !wr_st && (OP_CODE != csf_pkg::CSF_OP_NONE);

  assign alu.op = OP_VALID ? OP_CODE : csf_pkg::CSF_OP_NONE;
  assign alu.a = OPERAND_A;
  assign alu.b = OPERAND_B;
  assign alu.c_in = status_ff[`CSF_BIT_CARRY];

  csf_arith u_arith (
    .alu(alu.unit)
  );

  csf_sysflags u_sys (
    .kick(kick),
    .halt(halt),
    .expire(WDT_EXPIRE),
    .wdog_q(status_ff[`CSF_BIT_WDOG]),
    .sleep_q(status_ff[`CSF_BIT_SLEEP]),
    .nxt_wdog(nxt_wdog),
    .nxt_sleep(nxt_sleep)
  );

  // ==========================================================
  // Arithmetic flag next state
  always_comb begin
    // flags only move on listed ops
    nxt_arith = status_ff[`CSF_ARITH_MSB:0];
    if (wr_st) begin
      nxt_arith = WR_DATA[`CSF_ARITH_MSB:0];
    end else if (alu_op) begin
      if (alu.upd_c) begin
        nxt_arith[`CSF_BIT_CARRY] = alu.c_out;
      end
      if (alu.upd_acov) begin
        nxt_arith[`CSF_BIT_NIBBLE] = alu.ac_out;
        nxt_arith[`CSF_BIT_SRANGE] = alu.ov_out;
      end
      if (alu.upd_z) begin
        nxt_arith[`CSF_BIT_NULL] = alu.z_out;
      end
    end
  end

  // ==========================================================
  // Status register
  // Reset loads zero in the arithmetic bits; software must not rely on it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      status_ff <= `CSF_STATUS_RST;
    end else begin
      status_ff[7:6] <= `CSF_UNUSED_BITS;
      status_ff[`CSF_BIT_WDOG] <= nxt_wdog;
      status_ff[`CSF_BIT_SLEEP] <= nxt_sleep;
      status_ff[`CSF_ARITH_MSB:0] <= nxt_arith;
    end
  end

  // ==========================================================
  // ALU result
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      result_ff <= `CSF_BYTE_ZERO;
      result_valid_ff <= 1'b0;
    end else begin
      result_valid_ff <= alu_op;
      if (alu_op) begin
        result_ff <= alu.result;
      end
    end
  end

  assign STATUS = status_ff;
  assign RESULT = result_ff;
  assign RESULT_VALID = result_valid_ff;

endmodule // csf_status_flags

// ==== src/csf_sysflags.sv ====
// Purpose: Next state of watchdog and sleep flags
// Assumes: Expiry pulse is on the core clock
// Notes: Expiry wins over a clear in the same cycle
`timescale 1ns/1ps
module csf_sysflags (
  input wire logic kick,
  input wire logic halt,
  input wire logic expire,
  input wire logic wdog_q,
  input wire logic sleep_q,
  output logic nxt_wdog,
  output logic nxt_sleep
);

  // ==========================================================
  // System flags
  always_comb begin
    // watchdog clears on kick or halt, sets on expiry; sleep sets on halt, clears on kick
    nxt_wdog = wdog_q;
    if (kick || halt) begin
      nxt_wdog = 1'b0;
    end
    if (expire) begin
      nxt_wdog = 1'b1;
    end
    nxt_sleep = sleep_q;
    if (halt) begin
      nxt_sleep = 1'b1;
    end else if (kick) begin
      nxt_sleep = 1'b0;
    end
  end

endmodule // csf_sysflags

// ==== verification/csf_core_model.sv ====
// Purpose: Decoder side that presents instructions
// Assumes: Caller sits just after a rising edge
// Notes: Idle operands invert so stale values never match
`timescale 1ns/1ps
// ====================
// Decoder model
module csf_core_model (
  input wire logic CLK,
  output logic OP_VALID,
  output csf_pkg::csf_op_e OP_CODE,
  output csf_pkg::csf_byte_t OPERAND_A,
  output csf_pkg::csf_byte_t OPERAND_B,
  output csf_pkg::csf_byte_t WR_DATA,
  output logic WDT_EXPIRE
);
  initial begin
    OP_VALID = 1'b0;
    OP_CODE = csf_pkg::CSF_OP_NONE;
    {OPERAND_A, OPERAND_B, WR_DATA, WDT_EXPIRE} = 25'h000_0000;
  end
  // Held a whole cycle; no release at the edge so back-to-back calls assign once
  task automatic issue(input logic v, input csf_pkg::csf_op_e op, input csf_pkg::csf_byte_t a,
      input csf_pkg::csf_byte_t b, input logic x);
    {OP_VALID, OP_CODE, OPERAND_A, OPERAND_B, WR_DATA, WDT_EXPIRE} = {v, op, a, b, b, x};
    @(posedge CLK);
    #1;
  endtask
  task automatic idle();
    {OP_VALID, OP_CODE, WDT_EXPIRE} = {1'b0, csf_pkg::CSF_OP_NONE, 1'b0};
    {OPERAND_A, OPERAND_B, WR_DATA} = ~{OPERAND_A, OPERAND_B, WR_DATA};
    @(posedge CLK);
    #1;
  endtask
endmodule // csf_core_model

// ==== verification/csf_flags_asserts.sv ====
// Purpose: Port checks of the flag block
// Assumes: One clock, async low reset
// Notes: Arithmetic flags judged only after ops that set them
`timescale 1ns/1ps
// ====================
// Checker
module csf_flags_asserts (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic OP_VALID,
  input wire csf_pkg::csf_op_e OP_CODE,
  input wire csf_pkg::csf_byte_t OPERAND_A,
  input wire csf_pkg::csf_byte_t OPERAND_B,
  input wire csf_pkg::csf_byte_t WR_DATA,
  input wire logic WDT_EXPIRE,
  input wire csf_pkg::csf_byte_t STATUS,
  input wire csf_pkg::csf_byte_t RESULT,
  input wire logic RESULT_VALID
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic add, halt, kick, wr, rlc, zop;
  logic [8:0] sum;
  assign add = OP_VALID && OP_CODE == csf_pkg::CSF_OP_ADD;
  assign halt = OP_VALID && OP_CODE == csf_pkg::CSF_OP_HALT;
  assign kick = OP_VALID && OP_CODE == csf_pkg::CSF_OP_KICK;
  assign wr = OP_VALID && OP_CODE == csf_pkg::CSF_OP_WR_ST;
  assign rlc = OP_VALID && OP_CODE == csf_pkg::CSF_OP_RLC;
  assign zop = OP_VALID && OP_CODE >= csf_pkg::CSF_OP_ADD && OP_CODE <= csf_pkg::CSF_OP_CPL;
  assign sum = {1'b0, OPERAND_A} + {1'b0, OPERAND_B};
  AST_PAD: assert property (STATUS[7:6] == 2'h0) else $error("Pad bits set");
  AST_HALT: assert property (halt && !WDT_EXPIRE |=> STATUS[5:4] == 2'h1) else $error("Halt");
  AST_KICK: assert property (kick && !WDT_EXPIRE |=> STATUS[5:4] == 2'h0) else $error("Kick");
  AST_EXP: assert property (WDT_EXPIRE |=> STATUS[5]) else $error("Expiry");
  AST_SYS: assert property (!halt && !kick && !WDT_EXPIRE |=> $stable(STATUS[5:4])) else $error("Sys");
  AST_WR: assert property (wr |=> STATUS[3:0] == $past(WR_DATA[3:0])) else $error("Write");
  AST_ADD: assert property (add |=> {STATUS[0], RESULT} == $past(sum)) else $error("Add");
  AST_NOV: assert property (add |=> STATUS[1] == ($past(OPERAND_A[4]) ^ $past(OPERAND_B[4]) ^ RESULT[4])
    && STATUS[3] == ($past(OPERAND_A[7]) ^ $past(OPERAND_B[7]) ^ RESULT[7] ^ STATUS[0])) else $error("Nov");
  AST_Z: assert property (zop |=> STATUS[2] == (RESULT == 8'h00)) else $error("Zero");
  AST_RLC: assert property (rlc |=> {STATUS[0], RESULT} == {$past(OPERAND_A), $past(STATUS[0])}) else $error("Rlc");
  COV_HALT: cover property (halt ##1 kick);
  COV_EXP: cover property (WDT_EXPIRE && halt);
  COV_ADD: cover property (add ##1 zop);
endmodule // csf_flags_asserts
bind csf_status_flags csf_flags_asserts i_csf_flags_asserts (.CLK, .RSTN, .OP_VALID, .OP_CODE, .OPERAND_A,
  .OPERAND_B, .WR_DATA, .WDT_EXPIRE, .STATUS, .RESULT, .RESULT_VALID);

// ==== verification/csf_status_flags_tb_top.sv ====
// Purpose: Sequence test of the flag block
// Assumes: Result and status visible one edge after an op
// Notes: Arithmetic bits unchecked until first status write
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; $display("ERROR %0t %h %h", $time, g, e); end end
// ====================
// Bench
module csf_status_flags_tb_top;
  logic CLK, RSTN, OP_VALID, WDT_EXPIRE, RESULT_VALID;
  csf_pkg::csf_op_e OP_CODE;
  csf_pkg::csf_byte_t OPERAND_A, OPERAND_B, WR_DATA, STATUS, RESULT, exp_st, exp_res;
  int num_errors = 0;
  int checked = 0;
  logic [20:0] tbl [8] = '{{5'h01, 8'h0F, 8'h01}, {5'h01, 8'h80, 8'h80}, {5'h02, 8'hFF, 8'h00},
    {5'h04, 8'h10, 8'h01}, {5'h03, 8'h03, 8'h05}, {5'h04, 8'h05, 8'h03}, {5'h01, 8'h7F, 8'h01},
    {5'h03, 8'h80, 8'h01}};
  csf_core_model i_csf_core_model (.CLK, .OP_VALID, .OP_CODE, .OPERAND_A, .OPERAND_B, .WR_DATA, .WDT_EXPIRE);
  csf_status_flags i_csf_status_flags (.CLK, .RSTN, .OP_VALID, .OP_CODE, .OPERAND_A, .OPERAND_B, .WR_DATA,
    .WDT_EXPIRE, .STATUS, .RESULT, .RESULT_VALID);
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic run(input csf_pkg::csf_op_e op, input csf_pkg::csf_byte_t a, input csf_pkg::csf_byte_t b);
    logic [8:0] s;
    logic [4:0] n;
    csf_pkg::csf_byte_t bb;
    logic ci;
    bb = (op == csf_pkg::CSF_OP_SUB || op == csf_pkg::CSF_OP_SBC) ? ~b : b;
    ci = (op == csf_pkg::CSF_OP_ADD) ? 1'b0 : (op == csf_pkg::CSF_OP_SUB) ? 1'b1 : exp_st[0];
    s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    case (op)
      csf_pkg::CSF_OP_WR_ST: exp_st[3:0] = b[3:0];
      csf_pkg::CSF_OP_RLC: {exp_st[0], exp_res} = {a, exp_st[0]};
      csf_pkg::CSF_OP_RRC: {exp_res, exp_st[0]} = {exp_st[0], a};
      csf_pkg::CSF_OP_AND: {exp_res, exp_st[2]} = {a & b, (a & b) == 8'h00};
      csf_pkg::CSF_OP_OR: {exp_res, exp_st[2]} = {a | b, (a | b) == 8'h00};
      csf_pkg::CSF_OP_XOR: {exp_res, exp_st[2]} = {a ^ b, (a ^ b) == 8'h00};
      csf_pkg::CSF_OP_CPL: {exp_res, exp_st[2]} = {~a, ~a == 8'h00};
      csf_pkg::CSF_OP_INC: {exp_res, exp_st[2]} = {a + 8'h01, (a + 8'h01) == 8'h00};
      csf_pkg::CSF_OP_DEC: {exp_res, exp_st[2]} = {a - 8'h01, (a - 8'h01) == 8'h00};
      csf_pkg::CSF_OP_RL: exp_res = {a[6:0], a[7]};
      csf_pkg::CSF_OP_RR: exp_res = {a[0], a[7:1]};
      default: {exp_res, exp_st[3:0]} = {s[7:0], a[7] ^ bb[7] ^ s[7] ^ s[8], s[7:0] == 8'h00, n[4], s[8]};
    endcase
    i_csf_core_model.issue(1'b1, op, a, b, 1'b0);
    `CHK(STATUS, exp_st)
    if (op != csf_pkg::CSF_OP_WR_ST) begin
      `CHK({RESULT_VALID, RESULT}, {1'b1, exp_res})
    end else begin
      `CHK(RESULT_VALID, 1'b0)
    end
  endtask
  task automatic sys(input logic v, input csf_pkg::csf_op_e op, input logic x, input logic [1:0] e);
    i_csf_core_model.issue(v, op, 8'h00, 8'h00, x);
    exp_st[5:4] = e;
    `CHK(STATUS, exp_st)
  endtask
  initial begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    final_report();
  end
  initial begin
    RSTN = 1'b0;
    exp_st = 8'h00;
    exp_res = 8'h00;
    repeat (5) @(posedge CLK);
    #1 RSTN = 1'b1;
    `CHK(STATUS[7:4], 4'h0)
    run(csf_pkg::CSF_OP_WR_ST, 8'h00, 8'hFF);
    for (int i = 0; i < 8; i++) run(csf_pkg::csf_op_e'(tbl[i][20:16]), tbl[i][15:8], tbl[i][7:0]);
    run(csf_pkg::CSF_OP_WR_ST, 8'h00, 8'h01);
    run(csf_pkg::CSF_OP_RLC, 8'h80, 8'h00);
    run(csf_pkg::CSF_OP_RRC, 8'h02, 8'h00);
    run(csf_pkg::CSF_OP_AND, 8'hF0, 8'h0F);
    run(csf_pkg::CSF_OP_OR, 8'hF0, 8'h0F);
    run(csf_pkg::CSF_OP_INC, 8'hFF, 8'h00);
    run(csf_pkg::CSF_OP_DEC, 8'h00, 8'h00);
    run(csf_pkg::CSF_OP_XOR, 8'h5A, 8'h5A);
    run(csf_pkg::CSF_OP_CPL, 8'h0F, 8'h00);
    run(csf_pkg::CSF_OP_RL, 8'h81, 8'h00);
    run(csf_pkg::CSF_OP_RR, 8'h81, 8'h00);
    sys(1'b1, csf_pkg::CSF_OP_NONE, 1'b1, 2'h2);
    run(csf_pkg::CSF_OP_WR_ST, 8'h00, 8'hF0);
    sys(1'b0, csf_pkg::CSF_OP_HALT, 1'b0, 2'h2);
    sys(1'b1, csf_pkg::CSF_OP_HALT, 1'b0, 2'h1);
    sys(1'b1, csf_pkg::CSF_OP_HALT, 1'b1, 2'h3);
    sys(1'b1, csf_pkg::CSF_OP_KICK, 1'b0, 2'h0);
    sys(1'b1, csf_pkg::CSF_OP_HALT, 1'b0, 2'h1);
    sys(1'b1, csf_pkg::CSF_OP_KICK, 1'b1, 2'h2);
    i_csf_core_model.idle();
    RSTN = 1'b0;
    i_csf_core_model.idle();
    RSTN = 1'b1;
    `CHK(STATUS[7:4], 4'h0)
    final_report();
  end
endmodule // csf_status_flags_tb_top
